// [common/aacr_pkg.sv]
package aacr_pkg;
	// Register offsets on the control port.
	localparam logic [7:0] ANALOG_LOOP_CONTROL_OFS  = 8'h53;
	localparam logic [7:0] ANALOG_GAIN_OFS          = 8'h54;
	localparam logic [7:0] BIQUAD_WRITE_CONTROL_OFS = 8'h5c;

	// Reset values.
	localparam logic [7:0] ANALOG_LOOP_CONTROL_RST  = 8'h00;
	localparam logic [7:0] ANALOG_GAIN_RST          = 8'h00;
	localparam logic [7:0] BIQUAD_WRITE_CONTROL_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE      = 8'h00;

	// Field positions.
	localparam int FAST_HIZ_BIT          = 7;
	localparam int LOOP_BW_MSB           = 6;
	localparam int LOOP_BW_LSB           = 5;
	localparam int PHASE_BIT             = 0;
	localparam int GAIN_MSB              = 4;
	localparam int GAIN_LSB              = 0;
	localparam int FIRST_COEF_BIT        = 0;

	// Loop bandwidth codes.
	typedef enum logic [1:0] {
		AACR_BW_80K  = 2'h0,
		AACR_BW_100K = 2'h1,
		AACR_BW_120K = 2'h2,
		AACR_BW_175K = 2'h3
	} aacr_loop_bw_t;

	// One access on the control port.
	typedef struct packed {
		logic       wrEn;
		logic       rdEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} aacr_req_t;

	// Settings presented to the analog side.
	typedef struct packed {
		logic          fastHizEnable;
		aacr_loop_bw_t loopBandwidth;
		logic          phaseInPhase;
		logic [4:0]    analogGainLevel;
		logic          firstCoefficientMarker;
	} aacr_ctrl_t;
endpackage

// [rtl/amp_analog_control_regs.sv]
`timescale 1ns/10ps
// Function
// - Bits 6 to 5 of the analog loop control register pick the loop bandwidth of 80, 100, 120 or 175 kHz, reset 00.
// - Bit 0 of the analog loop control register drives left and right PWM in phase when 1, out of phase when 0.
// - Bits 4 to 0 of the analog gain register attenuate in 0.5 dB steps from 0 dB down to -15.5 dB, reset 00000.
// - The host sets bit 0 of the biquad write control register before a biquad's coefficients, and the device aligns on it.
// - The listed reserved fields of all three registers reset to zero.
// - Bit 7 of the analog loop control register enables fast high impedance on clock halt, reset 0.
module amp_analog_control_regs (
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire aacr_pkg::aacr_req_t req,
	output logic [7:0]             rdData,
	output logic                   rdValid,
	output aacr_pkg::aacr_ctrl_t   ctrl,
	output logic                   coefAlignPulse
);
	logic [7:0]           loopCtrl_q;
	logic [7:0]           loopCtrl_d;
	logic [7:0]           gain_q;
	logic [7:0]           gain_d;
	logic [7:0]           bqCtrl_q;
	logic [7:0]           bqCtrl_d;
	logic [7:0]           rdData_d;
	logic                 rdValid_d;
	logic                 align_d;
	aacr_pkg::aacr_ctrl_t ctrl_d;

	// One address match serves both the write and the read decode, so the two can never disagree.
	function automatic logic hit(input aacr_pkg::aacr_req_t r, input logic [7:0] ofs);
		hit = r.addr == ofs;
	endfunction

	always_comb begin
		loopCtrl_d = loopCtrl_q;
		gain_d     = gain_q;
		bqCtrl_d   = bqCtrl_q;
		align_d    = 1'h0;
		if (req.wrEn) begin
			// Reserved bits are stored as written so that readback matches.
			if (hit(req, aacr_pkg::ANALOG_LOOP_CONTROL_OFS)) begin
				loopCtrl_d = req.wrData;
			end
			if (hit(req, aacr_pkg::ANALOG_GAIN_OFS)) begin
				gain_d = req.wrData;
			end
			// The pulse marks each sequence start; the stored marker stays until the host clears it.
			if (hit(req, aacr_pkg::BIQUAD_WRITE_CONTROL_OFS)) begin
				bqCtrl_d = req.wrData;
				align_d  = req.wrData[aacr_pkg::FIRST_COEF_BIT];
			end
		end
	end

	// Reads see the stored value, so a read and a write in one cycle return the old contents.
	always_comb begin
		rdValid_d = req.rdEn;
		rdData_d  = aacr_pkg::UNMAPPED_READ_VALUE;
		if (req.rdEn) begin
			if (hit(req, aacr_pkg::ANALOG_LOOP_CONTROL_OFS)) begin
				rdData_d = loopCtrl_q;
			end else if (hit(req, aacr_pkg::ANALOG_GAIN_OFS)) begin
				rdData_d = gain_q;
			end else if (hit(req, aacr_pkg::BIQUAD_WRITE_CONTROL_OFS)) begin
				rdData_d = bqCtrl_q;
			end
		end
	end

	// Only the documented fields reach the analog side; reserved bits never steer anything.
	always_comb begin
		ctrl_d.fastHizEnable          = loopCtrl_d[aacr_pkg::FAST_HIZ_BIT];
		ctrl_d.loopBandwidth          = aacr_pkg::aacr_loop_bw_t'(
			loopCtrl_d[aacr_pkg::LOOP_BW_MSB:aacr_pkg::LOOP_BW_LSB]);
		ctrl_d.phaseInPhase           = loopCtrl_d[aacr_pkg::PHASE_BIT];
		ctrl_d.analogGainLevel        = gain_d[aacr_pkg::GAIN_MSB:aacr_pkg::GAIN_LSB];
		ctrl_d.firstCoefficientMarker = bqCtrl_d[aacr_pkg::FIRST_COEF_BIT];
	end

	// Stored contents; reserved bits are kept so that readback returns them.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			loopCtrl_q <= aacr_pkg::ANALOG_LOOP_CONTROL_RST;
			gain_q     <= aacr_pkg::ANALOG_GAIN_RST;
			bqCtrl_q   <= aacr_pkg::BIQUAD_WRITE_CONTROL_RST;
		end else begin
			loopCtrl_q <= loopCtrl_d;
			gain_q     <= gain_d;
			bqCtrl_q   <= bqCtrl_d;
		end
	end

	// The read answer stands for exactly one cycle after each read strobe.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData  <= aacr_pkg::UNMAPPED_READ_VALUE;
			rdValid <= 1'h0;
		end else begin
			rdData  <= rdData_d;
			rdValid <= rdValid_d;
		end
	end

	// Settings are taken from the next register values, so they follow a write by one edge.
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl           <= '0;
			coefAlignPulse <= 1'h0;
		end else begin
			ctrl           <= ctrl_d;
			coefAlignPulse <= align_d;
		end
	end

	// All checks share the one clock and stay silent while reset is held.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	a_bandwidth_write: assert property (
		req.wrEn && req.addr == aacr_pkg::ANALOG_LOOP_CONTROL_OFS
		|=> ctrl.loopBandwidth == $past(req.wrData[6:5]))
		else $error("Loop bandwidth does not follow the write.");

	a_phase_write: assert property (
		req.wrEn && req.addr == aacr_pkg::ANALOG_LOOP_CONTROL_OFS
		|=> ctrl.phaseInPhase == $past(req.wrData[0]))
		else $error("Phase control does not follow the write.");

	a_gain_write: assert property (
		req.wrEn && req.addr == aacr_pkg::ANALOG_GAIN_OFS
		|=> ctrl.analogGainLevel == $past(req.wrData[4:0]))
		else $error("Gain level does not follow the write.");

	a_gain_hold: assert property (
		!(req.wrEn && req.addr == aacr_pkg::ANALOG_GAIN_OFS) |=> $stable(ctrl.analogGainLevel))
		else $error("Gain level changed without a write.");

	a_align_pulse: assert property (
		coefAlignPulse |-> ctrl.firstCoefficientMarker && $past(req.wrEn)
		&& $past(req.addr) == aacr_pkg::BIQUAD_WRITE_CONTROL_OFS)
		else $error("Alignment pulse without a marker write.");

	a_reserved_inert: assert property (
		req.wrEn && req.addr == aacr_pkg::ANALOG_LOOP_CONTROL_OFS
		&& req.wrData[7:5] == loopCtrl_q[7:5] && req.wrData[0] == loopCtrl_q[0]
		|=> $stable(ctrl))
		else $error("Reserved bits affected the outputs.");

	a_fast_hiz: assert property (
		req.wrEn && req.addr == aacr_pkg::ANALOG_LOOP_CONTROL_OFS
		|=> ctrl.fastHizEnable == $past(req.wrData[7]))
		else $error("Fast high impedance enable does not follow the write.");

	a_readback: assert property (
		req.rdEn && !req.wrEn && req.addr == aacr_pkg::ANALOG_GAIN_OFS
		|=> rdValid && rdData == $past(gain_q))
		else $error("Gain readback differs from stored value.");

	a_unmapped_read: assert property (
		req.rdEn && req.addr != aacr_pkg::ANALOG_LOOP_CONTROL_OFS
		&& req.addr != aacr_pkg::ANALOG_GAIN_OFS && req.addr != aacr_pkg::BIQUAD_WRITE_CONTROL_OFS
		|=> rdValid && rdData == aacr_pkg::UNMAPPED_READ_VALUE)
		else $error("Unmapped read returned nonzero data.");

	// Holding checks catch a decoder that lets one register's write leak into another's fields.
	a_loop_hold: assert property (
		!(req.wrEn && req.addr == aacr_pkg::ANALOG_LOOP_CONTROL_OFS)
		|=> $stable(ctrl.loopBandwidth) && $stable(ctrl.phaseInPhase) && $stable(ctrl.fastHizEnable))
		else $error("Loop control settings changed without a write.");

	a_marker_write: assert property (
		req.wrEn && req.addr == aacr_pkg::BIQUAD_WRITE_CONTROL_OFS
		|=> ctrl.firstCoefficientMarker == $past(req.wrData[0]))
		else $error("Coefficient marker does not follow the write.");

	a_marker_hold: assert property (
		!(req.wrEn && req.addr == aacr_pkg::BIQUAD_WRITE_CONTROL_OFS) |=> $stable(ctrl.firstCoefficientMarker))
		else $error("Coefficient marker changed without a write.");

	a_align_raise: assert property (
		req.wrEn && req.addr == aacr_pkg::BIQUAD_WRITE_CONTROL_OFS && req.wrData[0]
		|=> coefAlignPulse)
		else $error("Marker write gave no alignment pulse.");

	a_align_single: assert property (
		!(req.wrEn && req.addr == aacr_pkg::BIQUAD_WRITE_CONTROL_OFS && req.wrData[0])
		|=> !coefAlignPulse)
		else $error("Alignment pulse outlasted its write.");

	a_gain_reserved: assert property (
		req.wrEn && req.addr == aacr_pkg::ANALOG_GAIN_OFS && req.wrData[4:0] == gain_q[4:0]
		|=> $stable(ctrl))
		else $error("Reserved gain bits affected the outputs.");

	a_bq_reserved: assert property (
		req.wrEn && req.addr == aacr_pkg::BIQUAD_WRITE_CONTROL_OFS && req.wrData[0] == bqCtrl_q[0]
		|=> $stable(ctrl))
		else $error("Reserved biquad control bits affected the outputs.");

	a_loop_readback: assert property (
		req.rdEn && req.addr == aacr_pkg::ANALOG_LOOP_CONTROL_OFS
		|=> rdValid && rdData == $past(loopCtrl_q))
		else $error("Loop control readback differs from stored value.");

	a_bq_readback: assert property (
		req.rdEn && req.addr == aacr_pkg::BIQUAD_WRITE_CONTROL_OFS
		|=> rdValid && rdData == $past(bqCtrl_q))
		else $error("Biquad control readback differs from stored value.");

	a_read_answer: assert property (
		req.rdEn |=> rdValid)
		else $error("Read strobe gave no answer.");

	a_read_idle: assert property (
		!req.rdEn |=> !rdValid && rdData == aacr_pkg::UNMAPPED_READ_VALUE)
		else $error("Read answer stood without a read strobe.");

	c_read_nonzero: cover property (rdValid && rdData != aacr_pkg::UNMAPPED_READ_VALUE);
	c_bw_175k: cover property (ctrl.loopBandwidth == aacr_pkg::AACR_BW_175K);
	c_max_atten: cover property (ctrl.analogGainLevel == 5'h1f);
	c_align: cover property (coefAlignPulse);
	c_in_phase: cover property (ctrl.phaseInPhase && ctrl.fastHizEnable);
endmodule // amp_analog_control_regs

// [verification/aacr_host_model.sv]
`timescale 1ns/10ps
// Host side of the control port; requests change only at the falling edge.
module aacr_host_model (
	input  wire logic           sys_clk,
	output aacr_pkg::aacr_req_t req,
	input  wire logic [7:0]     rdData,
	input  wire logic           rdValid
);
	initial req = '0;
	task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		req = '{wrEn: w, rdEn: r, addr: a, wrData: d};
		@(posedge sys_clk);
		#1;
	endtask
	// Reserved positions are written as zero except where a test means otherwise.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		put(1'h1, 1'h0, a, d);
	endtask
	task automatic rd(input logic [7:0] a, output logic [8:0] v);
		put(1'h0, 1'h1, a, 8'h00);
		v = {rdValid, rdData};
	endtask
endmodule // aacr_host_model

// [verification/amp_analog_control_regs_tb.sv]
`timescale 1ns/10ps
module amp_analog_control_regs_tb;
	logic                 sys_clk;
	logic                 rst_b;
	aacr_pkg::aacr_req_t  req;
	logic [7:0]           rdData;
	logic                 rdValid;
	aacr_pkg::aacr_ctrl_t ctrl;
	logic                 coefAlignPulse;
	logic [8:0]           rv;
	logic [7:0]           g [3] = '{8'h01, 8'h1f, 8'he5};
	int                   numErrors = 0;
	int                   nChecks = 0;
	amp_analog_control_regs dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .rdData(rdData),
		.rdValid(rdValid), .ctrl(ctrl), .coefAlignPulse(coefAlignPulse));
	aacr_host_model host_u (.sys_clk(sys_clk), .req(req), .rdData(rdData), .rdValid(rdValid));
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		nChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
		host_u.rd(a, rv);
		chk(rv, {1'h1, e});
	endtask
	task automatic endOfTest();
		$display("checks %0d errors %0d", nChecks, numErrors);
		if (numErrors == 0 && nChecks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		#100us;
		numErrors++;
		endOfTest();
	end
	initial begin
		rst_b = 1'b0;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_b = 1'b1;
		chk(ctrl, 10'h000);
		rdChk(8'h53, 8'h00);
		rdChk(8'h54, 8'h00);
		rdChk(8'h5c, 8'h00);
		// The last pass picks the wide bandwidth that fast switching needs.
		for (int i = 0; i < 4; i++) begin
			host_u.wr(8'h53, {i[0], i[1:0], 4'h0, i[1]});
			chk({ctrl.fastHizEnable, ctrl.loopBandwidth, ctrl.phaseInPhase}, {i[0], i[1:0], i[1]});
			rdChk(8'h53, {i[0], i[1:0], 4'h0, i[1]});
		end
		host_u.wr(8'h53, 8'h00);
		host_u.wr(8'h53, 8'h1e);
		chk({ctrl.fastHizEnable, ctrl.loopBandwidth, ctrl.phaseInPhase}, 10'h000);
		rdChk(8'h53, 8'h1e);
		for (int i = 0; i < 3; i++) begin
			host_u.wr(8'h54, g[i]);
			chk(ctrl.analogGainLevel, g[i][4:0]);
			rdChk(8'h54, g[i]);
		end
		host_u.wr(8'h54, 8'h05);
		chk(ctrl.analogGainLevel, 10'h005);
		host_u.wr(8'h5c, 8'h01);
		chk({coefAlignPulse, ctrl.firstCoefficientMarker}, 10'h003);
		rdChk(8'h5c, 8'h01);
		chk(coefAlignPulse, 10'h000);
		host_u.wr(8'h5c, 8'h00);
		chk({coefAlignPulse, ctrl.firstCoefficientMarker}, 10'h000);
		chk({rdValid, rdData}, 10'h000);
		host_u.wr(8'h5c, 8'hfe);
		chk({coefAlignPulse, ctrl.firstCoefficientMarker}, 10'h000);
		rdChk(8'h5c, 8'hfe);
		host_u.wr(8'h55, 8'hff);
		rdChk(8'h55, 8'h00);
		rdChk(8'h54, 8'h05);
		endOfTest();
	end
endmodule // amp_analog_control_regs_tb
